// ==== pkg/imde_cfg.svh ====
// register map, field positions, reset values and item layout constants
`ifndef IMDE_CFG_SVH
`define IMDE_CFG_SVH

`define IMDE_ADDR_CTRL       12'h000
`define IMDE_ADDR_CAT_EN     12'h004
`define IMDE_ADDR_EVT_NOTIFY 12'h008
`define IMDE_ADDR_IRQ_STATUS 12'h00c
`define IMDE_ADDR_IRQ_MASK   12'h010
`define IMDE_ADDR_STATUS     12'h014
`define IMDE_ADDR_FRAME_CNT  12'h018
`define IMDE_ADDR_TRIG_CNT   12'h01c

`define IMDE_CTRL_EMBED_BIT  0
`define IMDE_RST_CTRL        1'h0
`define IMDE_RST_CAT_EN      9'h000
`define IMDE_RST_EVT_NOTIFY  4'h0
`define IMDE_RST_IRQ_MASK    4'h0

`define IMDE_NUM_CAT         9
`define IMDE_NUM_EVT         4
`define IMDE_CAT_NONE        4'h9
`define IMDE_CAT_TIMESTAMP   4'h0
`define IMDE_CAT_GAIN        4'h1
`define IMDE_CAT_EXPOSURE    4'h2
`define IMDE_CAT_BRIGHT      4'h3
`define IMDE_CAT_WBAL        4'h4
`define IMDE_CAT_FRAMES      4'h5
`define IMDE_CAT_TRIGS       4'h6
`define IMDE_CAT_LINES       4'h7
`define IMDE_CAT_ROI         4'h8
`define IMDE_ITEM_SHORT      4'h4
`define IMDE_ITEM_LONG       4'h8

`endif

// ==== pkg/imde_pkg.sv ====
// types shared by the metadata embedder files
package imde_pkg;
    typedef enum logic [0:0] {ST_IDLE, ST_EMBED} imde_state_t;
    typedef enum logic [1:0] {EV_FRAME_START, EV_FRAME_END, EV_TRIGGER, EV_META_DONE} imde_evt_t;
    typedef logic [63:0] imde_word_t;
endpackage

// ==== src/imde_meta_store.sv ====
// per-frame snapshot store of metadata items, registered read port
`timescale 1ns/1ns
module imde_meta_store #(
    parameter int ENTRIES = 9
) (
    // clock and reset
    input  wire logic                   clk_sys,
    input  wire logic                   reset_n,
    // parallel load of all items
    input  wire logic                   wrAll,
    input  wire logic [ENTRIES*64-1:0]  wrData,
    // read port
    input  wire logic [3:0]             rdAddr,
    output imde_pkg::imde_word_t        rdData
);
    imde_pkg::imde_word_t mem [ENTRIES];
    imde_pkg::imde_word_t next_rdData;

    always_comb begin
        next_rdData = 64'h0;
        if (32'(rdAddr) < ENTRIES) begin
            next_rdData = mem[rdAddr];
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rdData <= 64'h0;
            for (int i = 0; i < ENTRIES; i++) begin
                mem[i] <= 64'h0;
            end
        end else begin
            rdData <= next_rdData;
            if (wrAll) begin
                for (int i = 0; i < ENTRIES; i++) begin
                    mem[i] <= wrData[i*64 +: 64];
                end
            end
        end
    end
endmodule // imde_meta_store

// ==== src/imde_embedder.sv ====
// image metadata embedder: stream insertion, events, apb registers
// Operation
// - each metadata byte goes in the low eight bits of one valid pixel
// - timestamp item is four bytes
// - gain item is four bytes, value 0..1023, upper bits zero
// - exposure item is four bytes in microseconds
// - brightness item is four bytes, 0..4095, upper bits zero
// - white balance is eight bytes, red green blue two bytes each
// - frame count and trigger count are four-byte full-range unsigned counts
// - line item is four bytes of current input and output line state
// - region item first gives column then row, two bytes each
// - region item then gives length then width, two bytes each
// - only enabled categories embed; item flow continues across lines
// - notified events produce an event message to the host
//
// Design decisions made here: the register offsets and the APB interface to the registers.
`timescale 1ns/1ns
`include "imde_cfg.svh"
module imde_embedder #(
    parameter int PIX_W  = 16,
    parameter int LINE_W = 8
) (
    // clock and reset
    input  wire logic                clk_sys,
    input  wire logic                reset_n,
    // apb slave
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [11:0]         paddr,
    input  wire logic [31:0]         pwdata,
    output logic      [31:0]         prdata,
    output logic                     pready,
    output logic                     pslverr,
    // pixel stream from the image source
    input  wire logic [PIX_W-1:0]    pixIn,
    input  wire logic                pixInValid,
    input  wire logic                pixInSof,
    input  wire logic                pixInEof,
    // pixel stream toward the host link
    output logic      [PIX_W-1:0]    pixOut,
    output logic                     pixOutValid,
    output logic                     pixOutSof,
    output logic                     pixOutEof,
    output logic                     pixOutMeta,
    // acquisition values, same clock
    input  wire logic [31:0]         timeStamp,
    input  wire logic [9:0]          gainValue,
    input  wire logic [31:0]         exposureUs,
    input  wire logic [11:0]         brightness,
    input  wire logic [11:0]         wbRed,
    input  wire logic [11:0]         wbGreen,
    input  wire logic [11:0]         wbBlue,
    input  wire logic [LINE_W-1:0]   lineOutState,
    input  wire logic [15:0]         roiColumn,
    input  wire logic [15:0]         roiRow,
    input  wire logic [15:0]         roiLength,
    input  wire logic [15:0]         roiWidth,
    // camera pins, asynchronous
    input  wire logic                extTrigger,
    input  wire logic [LINE_W-1:0]   lineInPins,
    // event messages and interrupt
    output logic                     evtValid,
    output imde_pkg::imde_evt_t      evtCode,
    output logic      [31:0]         evtStamp,
    output logic                     irq
);
    localparam int NC = `IMDE_NUM_CAT;
    localparam int NE = `IMDE_NUM_EVT;
    // package literals are not imported, so local aliases keep the state code readable
    localparam imde_pkg::imde_state_t ST_IDLE        = imde_pkg::ST_IDLE;
    localparam imde_pkg::imde_state_t ST_EMBED       = imde_pkg::ST_EMBED;
    localparam imde_pkg::imde_evt_t   EV_FRAME_START = imde_pkg::EV_FRAME_START;

    function automatic logic [3:0] nextCat(input logic [NC-1:0] en, input logic [3:0] from);
        logic [3:0] r;
        r = `IMDE_CAT_NONE;
        for (int i = NC - 1; i >= 0; i--) begin
            if (4'(i) >= from && en[i]) begin
                r = 4'(i);
            end
        end
        return r;
    endfunction

    function automatic logic [3:0] itemLen(input logic [3:0] cat);
        return (cat == `IMDE_CAT_WBAL || cat == `IMDE_CAT_ROI) ? `IMDE_ITEM_LONG
                                                                : `IMDE_ITEM_SHORT;
    endfunction

    // most significant byte leaves first
    function automatic logic [7:0] metaByte(input imde_pkg::imde_word_t w,
                                            input logic [3:0] cat, input logic [2:0] idx);
        logic [5:0] sh;
        sh = {3'(itemLen(cat) - 4'h1 - {1'b0, idx}), 3'h0};
        return 8'(w >> sh);
    endfunction

    // pin synchronisers
    logic [1:0]        trigSync;
    logic              trigLast;
    logic [LINE_W-1:0] lineMeta;
    logic [LINE_W-1:0] lineSync;
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            trigSync <= 2'h0;
            trigLast <= 1'b0;
            lineMeta <= '0;
            lineSync <= '0;
        end else begin
            trigSync <= {trigSync[0], extTrigger};
            trigLast <= trigSync[1];
            lineMeta <= lineInPins;
            lineSync <= lineMeta;
        end
    end
    wire logic trigRise = trigSync[1] && !trigLast;

    // register state
    logic          embedOn;
    logic [NC-1:0] catEn;
    logic [NE-1:0] evtNotify, irqMask, irqStatus;
    logic [31:0]   frameCount, trigCount;
    logic          next_embedOn;
    logic [NC-1:0] next_catEn;
    logic [NE-1:0] next_evtNotify, next_irqMask, next_irqStatus;
    logic [31:0]   next_frameCount, next_trigCount, next_prdata;
    logic          next_pready, next_pslverr;

    // stream state
    imde_pkg::imde_state_t st, next_st;
    logic [3:0]            cat, pcat, next_cat, next_pcat;
    logic [2:0]            byteIdx, next_byteIdx;
    logic [NC-1:0]         enSnap, next_enSnap;
    imde_pkg::imde_word_t  curWord, next_curWord, rdData;
    logic [PIX_W-1:0]      next_pixOut;
    logic                  next_pixOutMeta, metaDone;
    logic [NC*64-1:0]      liveWords;

    wire logic sofHit = pixInValid && pixInSof;
    wire logic eofHit = pixInValid && pixInEof;
    wire logic [3:0] firstCat = nextCat(catEn, 4'h0);

    assign liveWords = {
        {roiColumn, roiRow, roiLength, roiWidth},
        {32'h0, 32'(lineOutState) << 16 | 32'(lineSync)},
        {32'h0, trigCount},
        {32'h0, frameCount},
        {4'h0, wbRed, 4'h0, wbGreen, 4'h0, wbBlue, 16'h0},
        {32'h0, 20'h0, brightness},
        {32'h0, exposureUs},
        {32'h0, 22'h0, gainValue},
        {32'h0, timeStamp}
    };

    imde_meta_store #(.ENTRIES(NC)) u_store (
        .clk_sys (clk_sys),
        .reset_n (reset_n),
        .wrAll   (sofHit),
        .wrData  (liveWords),
        .rdAddr  (pcat),
        .rdData  (rdData)
    );

    always_comb begin
        next_st         = st;
        next_cat        = cat;
        next_pcat       = pcat;
        next_byteIdx    = byteIdx;
        next_enSnap     = enSnap;
        next_curWord    = curWord;
        next_pixOut     = pixIn;
        next_pixOutMeta = 1'b0;
        metaDone        = 1'b0;
        if (sofHit) begin
            next_st = ST_IDLE;
            if (embedOn && firstCat != `IMDE_CAT_NONE) begin
                next_st         = ST_EMBED;
                next_enSnap     = catEn;
                next_cat        = firstCat;
                next_pcat       = nextCat(catEn, 4'(firstCat + 4'h1));
                next_curWord    = liveWords[firstCat*64 +: 64];
                next_byteIdx    = 3'h1;
                next_pixOutMeta = 1'b1;
                next_pixOut     = {pixIn[PIX_W-1:8], metaByte(next_curWord, firstCat, 3'h0)};
            end
        end else if (pixInValid && st == ST_EMBED) begin
            // a line end does not stop the item flow, it resumes on the next line
            next_pixOutMeta = 1'b1;
            next_pixOut     = {pixIn[PIX_W-1:8], metaByte(curWord, cat, byteIdx)};
            if ({1'b0, byteIdx} == itemLen(cat) - 4'h1) begin
                next_byteIdx = 3'h0;
                if (pcat == `IMDE_CAT_NONE) begin
                    next_st  = ST_IDLE;
                    metaDone = 1'b1;
                end else begin
                    next_cat     = pcat;
                    next_curWord = rdData;
                    next_pcat    = nextCat(enSnap, 4'(pcat + 4'h1));
                end
            end else begin
                next_byteIdx = 3'(byteIdx + 3'h1);
            end
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            st          <= ST_IDLE;
            cat         <= `IMDE_CAT_NONE;
            pcat        <= `IMDE_CAT_NONE;
            byteIdx     <= 3'h0;
            enSnap      <= '0;
            curWord     <= 64'h0;
            pixOut      <= '0;
            pixOutValid <= 1'b0;
            pixOutSof   <= 1'b0;
            pixOutEof   <= 1'b0;
            pixOutMeta  <= 1'b0;
        end else begin
            st          <= next_st;
            cat         <= next_cat;
            pcat        <= next_pcat;
            byteIdx     <= next_byteIdx;
            enSnap      <= next_enSnap;
            curWord     <= next_curWord;
            pixOut      <= next_pixOut;
            pixOutValid <= pixInValid;
            pixOutSof   <= sofHit;
            pixOutEof   <= eofHit;
            pixOutMeta  <= next_pixOutMeta;
        end
    end

    // events: lowest code wins when several fire together
    wire logic [NE-1:0] evtRaw  = {metaDone, trigRise, eofHit, sofHit};
    wire logic [NE-1:0] evtSent = evtRaw & evtNotify;
    imde_pkg::imde_evt_t next_evtCode;
    always_comb begin
        next_evtCode = evtCode;
        for (int i = NE - 1; i >= 0; i--) begin
            if (evtSent[i]) begin
                next_evtCode = imde_pkg::imde_evt_t'(2'(i));
            end
        end
    end

    // apb: data is prepared in the setup cycle so pready can rise in the access cycle
    wire logic apbSetup = psel && !penable;
    wire logic apbDone  = psel && penable && pready;
    wire logic apbWr    = apbDone && pwrite;
    wire logic stRead   = apbDone && !pwrite && paddr == `IMDE_ADDR_IRQ_STATUS;

    always_comb begin
        next_embedOn    = embedOn;
        next_catEn      = catEn;
        next_evtNotify  = evtNotify;
        next_irqMask    = irqMask;
        next_frameCount = sofHit ? frameCount + 32'h1 : frameCount;
        next_trigCount  = trigRise ? trigCount + 32'h1 : trigCount;
        // a fresh event in the clearing read cycle survives
        next_irqStatus  = (stRead ? '0 : irqStatus) | evtSent;
        next_pready     = apbSetup;
        next_pslverr    = 1'b0;
        next_prdata     = 32'h0;
        if (apbWr) begin
            case (paddr)
                `IMDE_ADDR_CTRL:       next_embedOn   = pwdata[`IMDE_CTRL_EMBED_BIT];
                `IMDE_ADDR_CAT_EN:     next_catEn     = pwdata[NC-1:0];
                `IMDE_ADDR_EVT_NOTIFY: next_evtNotify = pwdata[NE-1:0];
                `IMDE_ADDR_IRQ_MASK:   next_irqMask   = pwdata[NE-1:0];
                default: ;
            endcase
        end
        if (apbSetup) begin
            case (paddr)
                `IMDE_ADDR_CTRL:       next_prdata = 32'(embedOn);
                `IMDE_ADDR_CAT_EN:     next_prdata = 32'(catEn);
                `IMDE_ADDR_EVT_NOTIFY: next_prdata = 32'(evtNotify);
                `IMDE_ADDR_IRQ_STATUS: next_prdata = 32'(irqStatus);
                `IMDE_ADDR_IRQ_MASK:   next_prdata = 32'(irqMask);
                `IMDE_ADDR_STATUS:     next_prdata = {27'h0, cat, st == ST_EMBED};
                `IMDE_ADDR_FRAME_CNT:  next_prdata = frameCount;
                `IMDE_ADDR_TRIG_CNT:   next_prdata = trigCount;
                default:               next_pslverr = 1'b1;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            embedOn    <= `IMDE_RST_CTRL;
            catEn      <= `IMDE_RST_CAT_EN;
            evtNotify  <= `IMDE_RST_EVT_NOTIFY;
            irqMask    <= `IMDE_RST_IRQ_MASK;
            irqStatus  <= '0;
            frameCount <= 32'h0;
            trigCount  <= 32'h0;
            prdata     <= 32'h0;
            pready     <= 1'b0;
            pslverr    <= 1'b0;
            evtValid   <= 1'b0;
            evtCode    <= EV_FRAME_START;
            evtStamp   <= 32'h0;
            irq        <= 1'b0;
        end else begin
            embedOn    <= next_embedOn;
            catEn      <= next_catEn;
            evtNotify  <= next_evtNotify;
            irqMask    <= next_irqMask;
            irqStatus  <= next_irqStatus;
            frameCount <= next_frameCount;
            trigCount  <= next_trigCount;
            prdata     <= next_prdata;
            pready     <= next_pready;
            pslverr    <= next_pslverr;
            evtValid   <= |evtSent;
            evtCode    <= next_evtCode;
            evtStamp   <= (|evtSent) ? timeStamp : evtStamp;
            irq        <= |(next_irqStatus & irqMask);
        end
    end

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);

    upper_bits_kept_a: assert property (pixInValid |=> pixOut[PIX_W-1:8] == $past(pixIn[PIX_W-1:8]))
        else $error("metadata disturbed upper pixel bits");
    ts_first_byte_a: assert property (sofHit && embedOn && catEn[0] |=>
            pixOutMeta && pixOut[7:0] == $past(timeStamp[31:24]))
        else $error("timestamp msb not first");
    gain_range_a: assert property (st == ST_EMBED && cat == `IMDE_CAT_GAIN |-> curWord[63:10] == 54'h0)
        else $error("gain item above 1023");
    exp_item_a: assert property (st == ST_EMBED && cat == `IMDE_CAT_EXPOSURE |-> curWord[63:32] == 32'h0)
        else $error("exposure item wider than four bytes");
    bright_range_a: assert property (st == ST_EMBED && cat == `IMDE_CAT_BRIGHT |-> curWord[63:12] == 52'h0)
        else $error("brightness item above 4095");
    wb_layout_a: assert property (st == ST_EMBED && cat == `IMDE_CAT_WBAL |->
            curWord[63:60] == 4'h0 && curWord[47:44] == 4'h0 && curWord[31:28] == 4'h0)
        else $error("white balance ratio above 4095");
    frame_count_a: assert property (sofHit |=> frameCount == $past(frameCount) + 32'h1)
        else $error("frame count did not step");
    line_item_a: assert property (st == ST_EMBED && cat == `IMDE_CAT_LINES |-> curWord[63:32] == 32'h0)
        else $error("line item wider than four bytes");
    roi_first_a: assert property (sofHit && embedOn && catEn == 9'h100 |=>
            pixOut[7:0] == $past(roiColumn[15:8]))
        else $error("region item does not open with column");
    roi_last_a: assert property (pixInValid && !sofHit && st == ST_EMBED && cat == `IMDE_CAT_ROI
            && byteIdx == 3'h7 |=> pixOut[7:0] == $past(curWord[7:0]))
        else $error("region item does not close with width low byte");
    embed_off_a: assert property (sofHit && !embedOn |=> !pixOutMeta ##1 !pixOutMeta)
        else $error("metadata inserted while disabled");
    evt_notified_a: assert property (evtValid |-> $past(evtNotify[evtCode]))
        else $error("event sent without notification");
    cat_order_a: assert property (st == ST_EMBED && $changed(cat) && $past(st) == ST_EMBED
            |-> cat > $past(cat) && enSnap[cat])
        else $error("category order broken");
    msb_first_a: assert property (pixInValid && st == ST_EMBED && !sofHit |=>
            pixOut[7:0] == $past(8'(curWord >> {3'(itemLen(cat) - 4'h1 - {1'b0, byteIdx}), 3'h0})))
        else $error("metadata byte order wrong");

    embed_frame_c: cover property (sofHit && embedOn ##[1:40] metaDone);
    irq_raise_c: cover property (evtValid ##1 irq);
    long_item_c: cover property (st == ST_EMBED && cat == `IMDE_CAT_ROI && byteIdx == 3'h7);
endmodule // imde_embedder

// ==== verification/imde_host_model.sv ====
// host side model: collects embedded metadata bytes and event messages
`timescale 1ns/1ns
module imde_host_model #(
    parameter int PIX_W = 16
) (
    // clock
    input  wire logic             clk_sys,
    // pixel stream from the device
    input  wire logic [PIX_W-1:0] pixOut,
    input  wire logic             pixOutValid,
    input  wire logic             pixOutMeta,
    // event messages
    input  wire logic             evtValid,
    input  wire imde_pkg::imde_evt_t evtCode
);
    logic [7:0]          metaQ[$];
    int                  evtCount = 0;
    imde_pkg::imde_evt_t lastEvt;
    // only the low byte of a marked pixel carries metadata
    always @(posedge clk_sys) begin
        if (pixOutValid === 1'b1 && pixOutMeta === 1'b1) begin
            metaQ.push_back(pixOut[7:0]);
        end
        if (evtValid === 1'b1) begin
            evtCount++;
            lastEvt = evtCode;
        end
    end
endmodule // imde_host_model

// ==== verification/image_metadata_embedder_tb.sv ====
// self-checking bench for the metadata embedder
`timescale 1ns/1ns
`include "imde_cfg.svh"
module image_metadata_embedder_tb;
    logic clk_sys = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, timeStamp = 32'h1234abcd, exposureUs = 32'h00012345;
    logic pready, pslverr, pixOutValid, pixOutMeta, evtValid, irq, lastErr;
    logic [15:0] pixIn = 16'h0, pixOut, roiColumn = 16'h0102, roiRow = 16'h0304;
    logic [15:0] roiLength = 16'h0506, roiWidth = 16'h0708;
    logic pixInValid = 1'b0, pixInSof = 1'b0, pixInEof = 1'b0, extTrigger = 1'b0;
    logic [9:0] gainValue = 10'h3ff;
    logic [11:0] brightness = 12'hfff, wbRed = 12'h801, wbGreen = 12'h7fe, wbBlue = 12'h0c3;
    logic [7:0] lineOutState = 8'ha5, lineInPins = 8'h3c, expQ[$];
    logic [31:0] rd, evtStamp;
    imde_pkg::imde_evt_t evtCode;
    int fails = 0, total_checks = 0, evDelta;

    always #5 clk_sys = ~clk_sys;

    imde_embedder i_dut (.clk_sys(clk_sys), .reset_n(reset_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pixIn(pixIn), .pixInValid(pixInValid), .pixInSof(pixInSof),
        .pixInEof(pixInEof), .pixOut(pixOut), .pixOutValid(pixOutValid), .pixOutSof(),
        .pixOutEof(), .pixOutMeta(pixOutMeta), .timeStamp(timeStamp), .gainValue(gainValue),
        .exposureUs(exposureUs), .brightness(brightness), .wbRed(wbRed), .wbGreen(wbGreen),
        .wbBlue(wbBlue), .lineOutState(lineOutState), .roiColumn(roiColumn), .roiRow(roiRow),
        .roiLength(roiLength), .roiWidth(roiWidth), .extTrigger(extTrigger),
        .lineInPins(lineInPins), .evtValid(evtValid), .evtCode(evtCode),
        .evtStamp(evtStamp), .irq(irq));

    imde_host_model i_host (.clk_sys(clk_sys), .pixOut(pixOut), .pixOutValid(pixOutValid),
        .pixOutMeta(pixOutMeta), .evtValid(evtValid), .evtCode(evtCode));

    task end_sim;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task check(input string what, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    // request held until pready is seen high at a rising edge
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd      = prdata;
        lastErr = pslverr;
        if (pready !== 1'b1) begin
            fails++;
            end_sim();
        end
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys);
    endtask

    task push_item(input logic [63:0] v, input int n);
        for (int k = n - 1; k >= 0; k--) expQ.push_back(v[k*8+:8]);
    endtask

    // expected byte stream, fixed category order, msb first
    task build(input logic [8:0] en, input logic [31:0] fc, input logic [31:0] tc);
        expQ.delete();
        if (en[0]) push_item({32'h0, timeStamp}, 4);
        if (en[1]) push_item({54'h0, gainValue}, 4);
        if (en[2]) push_item({32'h0, exposureUs}, 4);
        if (en[3]) push_item({52'h0, brightness}, 4);
        if (en[4]) push_item({4'h0, wbRed, 4'h0, wbGreen, 4'h0, wbBlue, 16'h0}, 8);
        if (en[5]) push_item({32'h0, fc}, 4);
        if (en[6]) push_item({32'h0, tc}, 4);
        if (en[7]) push_item({40'h0, lineOutState, 8'h0, lineInPins}, 4);
        if (en[8]) push_item({roiColumn, roiRow, roiLength, roiWidth}, 8);
    endtask

    // gapped frame; values change right after sof to prove the snapshot
    task send_frame(input int n, input logic [8:0] en, input logic [31:0] fc,
                    input logic [31:0] tc);
        int ev;
        build(en, fc, tc);
        i_host.metaQ.delete();
        ev = i_host.evtCount;
        for (int i = 0; i < n; i++) begin
            pixInValid <= 1'b1;
            pixInSof   <= (i == 0);
            pixInEof   <= (i == n - 1);
            pixIn      <= 16'h5a00 + 16'(i);
            @(posedge clk_sys);
            if (i == 0) begin
                timeStamp  <= timeStamp + 32'h00010001;
                roiWidth   <= roiWidth + 16'h0011;
                gainValue  <= gainValue - 10'h001;
            end
            if (i % 7 == 6) begin
                pixInValid <= 1'b0;
                @(posedge clk_sys);
            end
        end
        pixInValid <= 1'b0;
        pixInSof   <= 1'b0;
        pixInEof   <= 1'b0;
        repeat (6) @(posedge clk_sys);
        evDelta = i_host.evtCount - ev;
        check("metaCount", 32'(expQ.size()), 32'(i_host.metaQ.size()));
        for (int i = 0; i < expQ.size() && i < i_host.metaQ.size(); i++) begin
            check("metaByte", {24'h0, expQ[i]}, {24'h0, i_host.metaQ[i]});
        end
    endtask

    initial begin
        repeat (100000) @(posedge clk_sys);
        fails++;
        end_sim();
    end

    initial begin
        repeat (12) @(posedge clk_sys);
        reset_n <= 1'b1;
        @(posedge clk_sys);
        apb(1'b0, `IMDE_ADDR_CTRL, 32'h0);
        check("ctrlReset", 32'h0, rd);
        apb(1'b0, `IMDE_ADDR_CAT_EN, 32'h0);
        check("catReset", 32'h0, rd);
        apb(1'b0, `IMDE_ADDR_IRQ_MASK, 32'h0);
        check("maskReset", 32'h0, rd);
        apb(1'b0, 12'h020, 32'h0);
        check("unmappedErr", 32'h1, {31'h0, lastErr});
        apb(1'b1, `IMDE_ADDR_CAT_EN, 32'h000001ff);
        apb(1'b0, `IMDE_ADDR_CAT_EN, 32'h0);
        check("catBack", 32'h000001ff, rd);
        $display("test registers done");
        apb(1'b1, `IMDE_ADDR_EVT_NOTIFY, 32'hf);
        apb(1'b1, `IMDE_ADDR_IRQ_MASK, 32'hf);
        apb(1'b1, `IMDE_ADDR_CTRL, 32'h1);
        repeat (3) begin
            extTrigger <= 1'b1;
            repeat (4) @(posedge clk_sys);
            extTrigger <= 1'b0;
            repeat (4) @(posedge clk_sys);
        end
        send_frame(48, 9'h1ff, 32'h0, 32'h3);
        check("frameEvents", 32'h3, 32'(evDelta));
        check("lastEvt", 32'h1, 32'(i_host.lastEvt));
        check("irqHigh", 32'h1, {31'h0, irq});
        apb(1'b0, `IMDE_ADDR_TRIG_CNT, 32'h0);
        check("trigCount", 32'h3, rd);
        apb(1'b0, `IMDE_ADDR_FRAME_CNT, 32'h0);
        check("frameCount", 32'h1, rd);
        $display("test full frame done");
        apb(1'b0, `IMDE_ADDR_IRQ_STATUS, 32'h0);
        check("irqStatus", 32'hf, rd);
        apb(1'b0, `IMDE_ADDR_IRQ_STATUS, 32'h0);
        check("irqCleared", 32'h0, rd);
        repeat (2) @(posedge clk_sys);
        check("irqLow", 32'h0, {31'h0, irq});
        $display("test events done");
        apb(1'b1, `IMDE_ADDR_CAT_EN, 32'h00000102);
        send_frame(16, 9'h102, 32'h1, 32'h3);
        $display("test partial categories done");
        apb(1'b1, `IMDE_ADDR_CTRL, 32'h0);
        send_frame(16, 9'h000, 32'h2, 32'h3);
        $display("test embed off done");
        end_sim();
    end
endmodule // image_metadata_embedder_tb
